// File: rtl/ispe_core.sv
// Purpose: interrupt concentrator, status/pending/enable registers
// Assumes: simple synchronous register port, one access per cycle
// Notes:   reads return data one cycle after the request
//
// Contract
// - bits 7-0 flag DAC channel service
// - bit 8 set by DMA interrupt
// - bit 9 set by ADC FIFO threshold
// - bits 10, 11 counter and digital I/O
// - status writes only before hardware enable
// - written ones inject, zeros ignored
// - pending is status AND enable, 0x2004
// - pending reads one when active and enabled
// - enable at 0x2008 gates output
// - disabled sources still captured in status
// - masking keeps status, unmask fires immediately
// - enable read returns mask state
// - status at 0x2000, read and write
// - acknowledge ones clear status bits
// - master enable bit 0 gates output
// - hardware enable write-once, swaps sources
`timescale 1ns/1ps
module ispe_core
   import ispe_pkg::*;
(
   input  wire logic        clk_i,          // 10 MHz clock
   input  wire logic        rstn_i,         // async reset, low
   input  wire logic [7:0]  dac_irq_i,      // DAC channel service
   input  wire logic        dma_irq_i,      // DMA engine interrupt
   input  wire logic [11:0] adc_level_i,    // ADC FIFO sample count
   input  wire logic [11:0] adc_thresh_i,   // ADC full threshold
   input  wire logic        cnt_irq_i,      // counter interrupt
   input  wire logic        dio_irq_i,      // digital I/O interrupt
   input  wire logic        reg_wr_i,       // register write strobe
   input  wire logic        reg_rd_i,       // register read strobe
   input  wire logic [15:0] reg_addr_i,     // byte offset
   input  wire logic [31:0] reg_wdata_i,    // write data
   output logic      [31:0] reg_rdata_o,    // read data
   output logic             reg_rvalid_o,   // read data valid
   output logic             irq_o           // interrupt request
);
   logic [11:0] hw_src;
   logic [11:0] status;
   logic [11:0] enable_r, enable_nxt;
   logic        men_r, men_nxt;
   logic        hie_r, hie_nxt;
   logic [31:0] rdata_r, rdata_nxt;
   logic        rvalid_r;
   logic [11:0] pending;
   logic        wr_stat, wr_ack, wr_en, wr_set, wr_clr, wr_mer;
   logic [11:0] wd;

   // source vector
   always_comb begin
      hw_src[7:0] = dac_irq_i;
      hw_src[ISPE_BIT_DMA] = dma_irq_i;
      hw_src[ISPE_BIT_ADC] = (adc_level_i >= adc_thresh_i);
      hw_src[ISPE_BIT_CNT] = cnt_irq_i;
      hw_src[ISPE_BIT_DIO] = dio_irq_i;
   end

   assign wd      = reg_wdata_i[11:0];
   assign wr_stat = reg_wr_i && (reg_addr_i == ISPE_OFF_STATUS);
   assign wr_ack  = reg_wr_i && (reg_addr_i == ISPE_OFF_ACK);
   assign wr_en   = reg_wr_i && (reg_addr_i == ISPE_OFF_ENABLE);
   assign wr_set  = reg_wr_i && (reg_addr_i == ISPE_OFF_SETEN);
   assign wr_clr  = reg_wr_i && (reg_addr_i == ISPE_OFF_CLREN);
   assign wr_mer  = reg_wr_i && (reg_addr_i == ISPE_OFF_MASTER);

   genvar g;
   generate
      for (g = 0; g < ISPE_NSRC; g++) begin : g_src
         ispe_src_bit u_bit (
            .clk_i   (clk_i),
            .rstn_i  (rstn_i),
            .hw_i    (hw_src[g]),
            .hie_i   (hie_r),
            .swset_i (wr_stat && wd[g]),
            .ack_i   (wr_ack && wd[g]),
            .stat_o  (status[g])
         );
      end
   endgenerate

   // control registers
   always_comb begin
      enable_nxt = enable_r;
      men_nxt    = men_r;
      hie_nxt    = hie_r;
      if (wr_en) begin
         enable_nxt = wd;
      end
      if (wr_set) begin
         enable_nxt = enable_r | wd;
      end
      if (wr_clr) begin
         enable_nxt = enable_r & ~wd;
      end
      if (wr_mer) begin
         men_nxt = reg_wdata_i[ISPE_BIT_MEN];
         if (reg_wdata_i[ISPE_BIT_HIE]) begin
            hie_nxt = 1'b1;
         end
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         enable_r <= ISPE_RST_ENABLE;
         men_r    <= ISPE_RST_MEN;
         hie_r    <= ISPE_RST_HIE;
      end else begin
         enable_r <= enable_nxt;
         men_r    <= men_nxt;
         hie_r    <= hie_nxt;
      end
   end

   assign pending = status & enable_r;
   assign irq_o = men_r && (|pending);

   // read mux
   always_comb begin
      rdata_nxt = 32'h0000_0000;
      unique case (reg_addr_i)
         ISPE_OFF_STATUS:  rdata_nxt[11:0] = status;
         ISPE_OFF_PENDING: rdata_nxt[11:0] = pending;
         ISPE_OFF_ENABLE:  rdata_nxt[11:0] = enable_r;
         ISPE_OFF_MASTER:  rdata_nxt[1:0]  = {hie_r, men_r};
         default:          rdata_nxt = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rdata_r  <= 32'h0000_0000;
         rvalid_r <= 1'b0;
      end else begin
         rdata_r  <= reg_rd_i ? rdata_nxt : rdata_r;
         rvalid_r <= reg_rd_i;
      end
   end
   assign reg_rdata_o  = rdata_r;
   assign reg_rvalid_o = rvalid_r;

   // checks
   // unmasking a live source
   sequence s_unmask_live;
      wr_en && men_r && (|(status & wd));
   endsequence
   property p_irq_gate;
      @(posedge clk_i) disable iff (!rstn_i)
         s_unmask_live |=> irq_o;
   endproperty
   a_irq_gate: assert property (p_irq_gate)
      else $error("unmasked live source gave no irq");

   property p_men_off;
      @(posedge clk_i) disable iff (!rstn_i)
         (wr_mer && !reg_wdata_i[ISPE_BIT_MEN]) |=> !irq_o;
   endproperty
   a_men_off: assert property (p_men_off)
      else $error("master off did not mask irq");

   sequence s_locked_write;
      hie_r && wr_stat && !(|hw_src) && !(|status);
   endsequence
   property p_sw_locked;
      @(posedge clk_i) disable iff (!rstn_i)
         s_locked_write |=> (status == '0);
   endproperty
   a_sw_locked: assert property (p_sw_locked)
      else $error("status write took effect after hardware enable");

   property p_sw_inject;
      @(posedge clk_i) disable iff (!rstn_i)
         (!hie_r && wr_stat && !wr_ack)
         |=> ((status & $past(wd)) == $past(wd));
   endproperty
   a_sw_inject: assert property (p_sw_inject)
      else $error("software inject did not set status");

   property p_ack_clear;
      @(posedge clk_i) disable iff (!rstn_i)
         (wr_ack && wd[0] && !hie_r && !wr_stat) |=> !status[0];
   endproperty
   a_ack_clear: assert property (p_ack_clear)
      else $error("acknowledge did not clear status");

   property p_hie_once;
      @(posedge clk_i) disable iff (!rstn_i)
         hie_r |=> hie_r;
   endproperty
   a_hie_once: assert property (p_hie_once)
      else $error("hardware enable cleared without reset");

   property p_hw_capture;
      @(posedge clk_i) disable iff (!rstn_i)
         (hie_r && dma_irq_i) |=> status[ISPE_BIT_DMA];
   endproperty
   a_hw_capture: assert property (p_hw_capture)
      else $error("dma interrupt not captured");

   property p_mask_keeps;
      @(posedge clk_i) disable iff (!rstn_i)
         (status[ISPE_BIT_CNT] && wr_en && !wd[ISPE_BIT_CNT] && !wr_ack)
         |=> status[ISPE_BIT_CNT] && !pending[ISPE_BIT_CNT];
   endproperty
   a_mask_keeps: assert property (p_mask_keeps)
      else $error("masking cleared status");

   property p_en_read;
      @(posedge clk_i) disable iff (!rstn_i)
         (reg_rd_i && reg_addr_i == ISPE_OFF_ENABLE)
         |=> reg_rvalid_o && reg_rdata_o == {20'h00000, $past(enable_r)};
   endproperty
   a_en_read: assert property (p_en_read)
      else $error("enable read mismatch");

   property p_adc_cmp;
      @(posedge clk_i) disable iff (!rstn_i)
         (hie_r && adc_level_i >= adc_thresh_i) |=> status[ISPE_BIT_ADC];
   endproperty
   a_adc_cmp: assert property (p_adc_cmp)
      else $error("adc threshold not captured");
endmodule : ispe_core

// File: rtl/ispe_pkg.sv
// Purpose: constants for the interrupt status/pending/enable core
// Assumes: 32-bit register window, byte offsets within the host window
// Notes:   twelve sources, bits above 11 read as zero
package ispe_pkg;
   localparam int          ISPE_NSRC        = 12;
   localparam logic [15:0] ISPE_OFF_STATUS  = 16'h2000;
   localparam logic [15:0] ISPE_OFF_PENDING = 16'h2004;
   localparam logic [15:0] ISPE_OFF_ENABLE  = 16'h2008;
   localparam logic [15:0] ISPE_OFF_ACK     = 16'h200c;
   localparam logic [15:0] ISPE_OFF_SETEN   = 16'h2010;
   localparam logic [15:0] ISPE_OFF_CLREN   = 16'h2014;
   localparam logic [15:0] ISPE_OFF_MASTER  = 16'h201c;
   localparam int          ISPE_BIT_DMA     = 8;
   localparam int          ISPE_BIT_ADC     = 9;
   localparam int          ISPE_BIT_CNT     = 10;
   localparam int          ISPE_BIT_DIO     = 11;
   localparam int          ISPE_BIT_MEN     = 0;
   localparam int          ISPE_BIT_HIE     = 1;
   localparam logic [11:0] ISPE_RST_STATUS  = 12'h000;
   localparam logic [11:0] ISPE_RST_ENABLE  = 12'h000;
   localparam logic        ISPE_RST_MEN     = 1'b0;
   localparam logic        ISPE_RST_HIE     = 1'b0;
endpackage : ispe_pkg

// File: rtl/ispe_src_bit.sv
// Purpose: one sticky status bit with ack clear and software injection
// Assumes: hw_i already synchronous to clk_i
// Notes:   set wins over acknowledge in the same cycle
`timescale 1ns/1ps
module ispe_src_bit (
   input  wire logic clk_i,    // clock
   input  wire logic rstn_i,   // async reset, low
   input  wire logic hw_i,     // hardware source level
   input  wire logic hie_i,    // hardware inputs enabled
   input  wire logic swset_i,  // software inject pulse
   input  wire logic ack_i,    // acknowledge pulse
   output logic      stat_o    // status bit
);
   logic stat_nxt;
   always_comb begin
      stat_nxt = stat_o;
      if (ack_i) begin
         stat_nxt = 1'b0;
      end
      if ((hie_i && hw_i) || (!hie_i && swset_i)) begin
         stat_nxt = 1'b1;
      end
   end
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         stat_o <= 1'b0;
      end else begin
         stat_o <= stat_nxt;
      end
   end
endmodule : ispe_src_bit

// File: sim/ispe_host_model.sv
// Purpose: host-side register access model for the interrupt core
// Assumes: one access per cycle, read answer one cycle after the strobe
// Notes:   idle address and data show the inverse of the last access
`timescale 1ns/1ps
module ispe_host_model (
   input  wire logic        clk_i,        // clock
   output logic             reg_wr_o,     // write strobe
   output logic             reg_rd_o,     // read strobe
   output logic      [15:0] reg_addr_o,   // byte offset
   output logic      [31:0] reg_wdata_o,  // write data
   input  wire logic [31:0] reg_rdata_i,  // read data
   input  wire logic        reg_rvalid_i  // read data valid
);
   initial begin
      reg_wr_o    = 1'b0;
      reg_rd_o    = 1'b0;
      reg_addr_o  = 16'h0000;
      reg_wdata_o = 32'h0000_0000;
   end

   // one-cycle strobe, then release the bus
   task automatic drive(input logic w, input logic [15:0] a,
                        input logic [31:0] d);
      @(posedge clk_i);
      #1;
      reg_wr_o    = w;
      reg_rd_o    = ~w;
      reg_addr_o  = a;
      reg_wdata_o = d;
      @(posedge clk_i);
      #1;
      reg_wr_o    = 1'b0;
      reg_rd_o    = 1'b0;
      reg_addr_o  = ~a;
      reg_wdata_o = ~d;
   endtask : drive

   task automatic wr(input logic [15:0] a, input logic [31:0] d);
      drive(1'b1, a, d);
   endtask : wr

   task automatic rd(input logic [15:0] a, output logic [31:0] d,
                     output logic v);
      drive(1'b0, a, 32'h0000_0000);
      d = reg_rdata_i;
      v = reg_rvalid_i;
   endtask : rd
endmodule : ispe_host_model

// File: sim/test_irq_status_pending_enable.sv
// Purpose: self-checking bench for the interrupt core
// Assumes: host model drives the register port
// Notes:   sources change 1 ns after the rising edge
`timescale 1ns/1ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin err_count++; \
   $display("CHECK FAILED t=%0t got %h exp %h", $time, a, e); end end
module test_irq_status_pending_enable;
   import ispe_pkg::*;
   logic        clk_i = 1'b0;
   logic        rstn_i = 1'b0;
   logic [7:0]  dac_irq_i = 8'hff;
   logic        dma_irq_i = 1'b1;
   logic [11:0] adc_level_i = 12'h005;
   logic [11:0] adc_thresh_i = 12'h005;
   logic        cnt_irq_i = 1'b1;
   logic        dio_irq_i = 1'b1;
   logic        reg_wr_i, reg_rd_i, reg_rvalid_o, irq_o;
   logic [15:0] reg_addr_i;
   logic [31:0] reg_wdata_i, reg_rdata_o;
   int          err_count = 0;
   int          total_checks = 0;

   always #50 clk_i = ~clk_i;

   ispe_core ispe_core_inst (.clk_i(clk_i), .rstn_i(rstn_i),
      .dac_irq_i(dac_irq_i), .dma_irq_i(dma_irq_i),
      .adc_level_i(adc_level_i), .adc_thresh_i(adc_thresh_i),
      .cnt_irq_i(cnt_irq_i), .dio_irq_i(dio_irq_i), .reg_wr_i(reg_wr_i),
      .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i),
      .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
      .reg_rvalid_o(reg_rvalid_o), .irq_o(irq_o));
   ispe_host_model ispe_host_model_inst (.clk_i(clk_i),
      .reg_wr_o(reg_wr_i), .reg_rd_o(reg_rd_i), .reg_addr_o(reg_addr_i),
      .reg_wdata_o(reg_wdata_i), .reg_rdata_i(reg_rdata_o),
      .reg_rvalid_i(reg_rvalid_o));

   task automatic wr(input logic [15:0] a, input logic [31:0] d);
      ispe_host_model_inst.wr(a, d);
   endtask : wr

   // read and compare, valid must come one cycle later
   task automatic rc(input logic [15:0] a, input logic [31:0] e);
      logic [31:0] d;
      logic        v;
      ispe_host_model_inst.rd(a, d, v);
      `CHK(v, 1'b1)
      `CHK(d, e)
   endtask : rc

   task automatic results;
      $display("checks %0d errors %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : results

   initial begin
      #300000;
      err_count++;
      results();
   end

   initial begin
      repeat (4) @(posedge clk_i);
      #1 rstn_i = 1'b1;
      `CHK(irq_o, 1'b0)
      rc(ISPE_OFF_ENABLE, 32'h0);
      rc(ISPE_OFF_STATUS, 32'h0);
      wr(ISPE_OFF_STATUS, 32'hffff_f0a5);
      rc(ISPE_OFF_STATUS, 32'h0a5);
      wr(ISPE_OFF_STATUS, 32'h0);
      rc(ISPE_OFF_STATUS, 32'h0a5);
      wr(ISPE_OFF_ENABLE, 32'hffff_f00f);
      rc(ISPE_OFF_ENABLE, 32'h00f);
      rc(ISPE_OFF_PENDING, 32'h005);
      `CHK(irq_o, 1'b0)
      wr(ISPE_OFF_MASTER, 32'h1);
      `CHK(irq_o, 1'b1)
      wr(ISPE_OFF_ENABLE, 32'h0);
      `CHK(irq_o, 1'b0)
      rc(ISPE_OFF_STATUS, 32'h0a5);
      rc(ISPE_OFF_PENDING, 32'h0);
      wr(ISPE_OFF_ENABLE, 32'h1);
      `CHK(irq_o, 1'b1)
      wr(ISPE_OFF_ACK, 32'h1);
      `CHK(irq_o, 1'b0)
      rc(ISPE_OFF_STATUS, 32'h0a4);
      wr(ISPE_OFF_ACK, 32'hffff_ffff);
      rc(ISPE_OFF_STATUS, 32'h0);
      wr(ISPE_OFF_SETEN, 32'h0f0);
      wr(ISPE_OFF_CLREN, 32'h001);
      rc(ISPE_OFF_ENABLE, 32'h0f0);
      rc(16'h2018, 32'h0);
      dac_irq_i = 8'h00;
      dma_irq_i = 1'b0;
      adc_level_i = 12'h004;
      cnt_irq_i = 1'b0;
      dio_irq_i = 1'b0;
      wr(ISPE_OFF_MASTER, 32'h3);
      rc(ISPE_OFF_MASTER, 32'h3);
      wr(ISPE_OFF_STATUS, 32'h800);
      rc(ISPE_OFF_STATUS, 32'h0);
      @(posedge clk_i);
      #1 dac_irq_i = 8'h81;
      dma_irq_i = 1'b1;
      adc_level_i = 12'h005;
      cnt_irq_i = 1'b1;
      dio_irq_i = 1'b1;
      @(posedge clk_i);
      #1 dac_irq_i = 8'h00;
      dma_irq_i = 1'b0;
      adc_level_i = 12'h004;
      cnt_irq_i = 1'b0;
      dio_irq_i = 1'b0;
      rc(ISPE_OFF_STATUS, 32'hf81);
      rc(ISPE_OFF_PENDING, 32'h080);
      `CHK(irq_o, 1'b1)
      wr(ISPE_OFF_ACK, 32'h280);
      rc(ISPE_OFF_STATUS, 32'hd01);
      `CHK(irq_o, 1'b0)
      wr(ISPE_OFF_ENABLE, 32'h400);
      `CHK(irq_o, 1'b1)
      wr(ISPE_OFF_ENABLE, 32'h000);
      `CHK(irq_o, 1'b0)
      rc(ISPE_OFF_STATUS, 32'hd01);
      wr(ISPE_OFF_ENABLE, 32'h400);
      `CHK(irq_o, 1'b1)
      wr(ISPE_OFF_MASTER, 32'h0);
      `CHK(irq_o, 1'b0)
      rc(ISPE_OFF_MASTER, 32'h2);
      @(posedge clk_i);
      #1 rstn_i = 1'b0;
      @(posedge clk_i);
      #1 rstn_i = 1'b1;
      rc(ISPE_OFF_MASTER, 32'h0);
      rc(ISPE_OFF_STATUS, 32'h0);
      rc(ISPE_OFF_ENABLE, 32'h0);
      wr(ISPE_OFF_STATUS, 32'h800);
      rc(ISPE_OFF_STATUS, 32'h800);
      results();
   end
endmodule : test_irq_status_pending_enable
